// ===== pfr_consts.svh
/*
  register offsets, field positions, reset values, pin and pwm counts and bus responses of the pin-function remap block.
  assumes inclusion by bare name from package and modules.
*/
`ifndef PFR_CONSTS_SVH
`define PFR_CONSTS_SVH

`define PFR_OFS_BOOT_CFG0    12'h000
`define PFR_OFS_AUX_CTRL1    12'h004
`define PFR_OFS_TWOWIRE_CTRL 12'h008
`define PFR_OFS_CONV_CTRL1   12'h00C
`define PFR_OFS_PWM_SEL      12'h010
`define PFR_OFS_CLK_CTRL     12'h014
`define PFR_OFS_PINT_EN      12'h018
`define PFR_OFS_PIN_STATUS   12'h01C

`define PFR_BIT_RST_DIS      2
`define PFR_BIT_UART_SWAP    2
`define PFR_BIT_TW_REMAP     0
`define PFR_BIT_TRIG_REMAP   6
`define PFR_BIT_EXT_CLK      0

`define PFR_RST_BOOT_CFG0    8'hFF
`define PFR_RST_BYTE         8'h00

`define PFR_NPINS            18
`define PFR_NPWM             6

`define PFR_RESP_OKAY        2'h0
`define PFR_RESP_SLVERR      2'h2
`endif

// ===== pfr_pkg.sv
/*
  types of the pin-function remap block.
  assumes pfr_consts.svh is on the include path.
*/
`include "pfr_consts.svh"
package pfr_pkg;
  // per-pin drive towards the pad
  typedef struct packed {
    logic [`PFR_NPINS-1:0] out;
    logic [`PFR_NPINS-1:0] oe;
  } pfr_pad_drv_t;

  // peripheral-side functions routed onto pads
  typedef struct packed {
    logic                 uart0_txd;
    logic                 twowire_scl_o;
    logic                 twowire_scl_oe;
    logic                 twowire_sda_o;
    logic                 twowire_sda_oe;
    logic [`PFR_NPWM-1:0] pwm;
  } pfr_periph_out_t;

  // functions recovered from pads
  typedef struct packed {
    logic uart0_rxd;
    logic twowire_scl_i;
    logic twowire_sda_i;
    logic conv_ext_trigger;
    logic ext_clock_in;
    logic port2_bit0;
    logic port3_bit0;
    logic device_reset_n;
  } pfr_periph_in_t;

  typedef enum logic [2:0] {
    PFR_ST_IDLE = 3'b001,
    PFR_ST_WRSP = 3'b010,
    PFR_ST_RRSP = 3'b100
  } pfr_bus_st_t;
endpackage

// ===== pfr_sync.sv
/*
  two-flop synchroniser bank for pad inputs.
  assumes a single clock aclk and synchronous active-low reset.
*/
`timescale 1ns/10ps
module pfr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // pfr_sync

// ===== pfr_remap.sv
/*
  pin-function remap block: axi4-lite control registers steering pad routing.
  assumes pads are resolved outside from out/oe; pad inputs are asynchronous.
  pad index map: 0 P0.6, 1 P0.7, 2 P1.3, 3 P1.4, 4 P0.2, 5 P1.6, 6 P0.4,
  7 port2_bit0/reset, 8 port3_bit0/osc-in, 9..14 pwm-capable pads for channels 0..5, rest gpio.
*/
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "pfr_consts.svh"
module pfr_remap #(
  parameter int NPINS = `PFR_NPINS,
  parameter int NPWM  = `PFR_NPWM
) (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address and data
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // pads
  input  wire logic [NPINS-1:0]        pad_in,
  output logic [NPINS-1:0]             pad_out,
  output logic [NPINS-1:0]             pad_oe,
  output logic                         pad_rst_pullup,
  // gpio side
  input  wire logic [NPINS-1:0]        gpio_out,
  input  wire logic [NPINS-1:0]        gpio_oe,
  output logic [NPINS-1:0]             gpio_in,
  // peripherals
  input  wire pfr_pkg::pfr_periph_out_t periph_out,
  output pfr_pkg::pfr_periph_in_t      periph_in,
  output logic [NPINS-1:0]             pin_int_src
);
  localparam int P_TXD = 0, P_RXD = 1, P_SCL = 2, P_SDA = 3, P_ASCL = 4, P_ASDA = 5;
  localparam int P_TRIG = 6, P_RST = 7, P_OSC = 8, P_PWM0 = 9;

  // registers
  logic [7:0]       boot_cfg0_r, aux_ctrl1_r, twowire_ctrl_r, conv_ctrl1_r, clk_ctrl_r;
  logic [NPWM-1:0]  pwm_sel_r;
  logic [NPINS-1:0] pint_en_r;
  pfr_pkg::pfr_bus_st_t st_r, st_nxt;
  logic             aw_got_r, w_got_r;
  logic [11:0]      awaddr_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic [NPINS-1:0] pin_s;

  // pad inputs through two flops; reset pad idles high
  pfr_sync #(.WIDTH(NPINS), .INIT({NPINS{1'b1}})) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pad_in),
    .q       (pin_s)
  );

  function automatic logic [7:0] pfr_merge(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
    pfr_merge = s[0] ? d[7:0] : old;
  endfunction

  // decode of control bits
  wire rst_pin_en  = boot_cfg0_r[`PFR_BIT_RST_DIS];
  wire uart_swap   = aux_ctrl1_r[`PFR_BIT_UART_SWAP];
  wire tw_remap    = twowire_ctrl_r[`PFR_BIT_TW_REMAP];
  wire trig_remap  = conv_ctrl1_r[`PFR_BIT_TRIG_REMAP];
  wire ext_clk     = clk_ctrl_r[`PFR_BIT_EXT_CLK];
  wire tx_pin      = uart_swap ? P_RXD[0] : P_TXD[0];   // index low bit selects pad 0/1
  wire scl_pin_sel = tw_remap;

  // bus handshake
  wire aw_hs    = s_axi_awvalid && !aw_got_r && st_r == pfr_pkg::PFR_ST_IDLE;
  wire w_hs     = s_axi_wvalid && !w_got_r && st_r == pfr_pkg::PFR_ST_IDLE;
  wire aw_have  = aw_got_r || aw_hs;
  wire w_have   = w_got_r || w_hs;
  wire wr_go    = aw_have && w_have && st_r == pfr_pkg::PFR_ST_IDLE;
  wire rd_go    = s_axi_arvalid && st_r == pfr_pkg::PFR_ST_IDLE && !wr_go && !aw_got_r && !w_got_r;
  wire [11:0] wa = aw_got_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd = w_got_r ? wdata_r : s_axi_wdata;
  wire [3:0]  ws = w_got_r ? wstrb_r : s_axi_wstrb;
  wire wr_hit   = wa == `PFR_OFS_BOOT_CFG0 || wa == `PFR_OFS_AUX_CTRL1 || wa == `PFR_OFS_TWOWIRE_CTRL ||
                  wa == `PFR_OFS_CONV_CTRL1 || wa == `PFR_OFS_PWM_SEL || wa == `PFR_OFS_CLK_CTRL ||
                  wa == `PFR_OFS_PINT_EN;
  logic [31:0] rd_val;
  logic        rd_hit;

  // read mux; status shows synchronised pad levels
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `PFR_OFS_BOOT_CFG0:    rd_val = {24'h000000, boot_cfg0_r};
      `PFR_OFS_AUX_CTRL1:    rd_val = {24'h000000, aux_ctrl1_r};
      `PFR_OFS_TWOWIRE_CTRL: rd_val = {24'h000000, twowire_ctrl_r};
      `PFR_OFS_CONV_CTRL1:   rd_val = {24'h000000, conv_ctrl1_r};
      `PFR_OFS_PWM_SEL:      rd_val = {{(32-NPWM){1'b0}}, pwm_sel_r};
      `PFR_OFS_CLK_CTRL:     rd_val = {24'h000000, clk_ctrl_r};
      `PFR_OFS_PINT_EN:      rd_val = {{(32-NPINS){1'b0}}, pint_en_r};
      `PFR_OFS_PIN_STATUS:   rd_val = {{(32-NPINS){1'b0}}, pin_s};
      default: begin
        rd_val = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // bus state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      pfr_pkg::PFR_ST_IDLE: if (wr_go) st_nxt = pfr_pkg::PFR_ST_WRSP;
                            else if (rd_go) st_nxt = pfr_pkg::PFR_ST_RRSP;
      pfr_pkg::PFR_ST_WRSP: if (s_axi_bready) st_nxt = pfr_pkg::PFR_ST_IDLE;
      pfr_pkg::PFR_ST_RRSP: if (s_axi_rready) st_nxt = pfr_pkg::PFR_ST_IDLE;
      default:              st_nxt = pfr_pkg::PFR_ST_IDLE;
    endcase
  end

  // handshake and response flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= pfr_pkg::PFR_ST_IDLE;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PFR_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PFR_RESP_OKAY;
    end else begin
      st_r <= st_nxt;
      if (aw_hs) awaddr_r <= s_axi_awaddr;
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_got_r <= wr_go ? 1'b0 : aw_have;
      w_got_r <= wr_go ? 1'b0 : w_have;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `PFR_RESP_OKAY : `PFR_RESP_SLVERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? `PFR_RESP_OKAY : `PFR_RESP_SLVERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  // ready flags are flops loaded from the handshake strobes, so they rise one edge after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= aw_hs;
      s_axi_wready <= w_hs;
      s_axi_arready <= rd_go;
    end
  end

  // control registers, low byte lane only; pin interrupt enables take write data bits 17:0 regardless of strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_cfg0_r <= `PFR_RST_BOOT_CFG0;
      aux_ctrl1_r <= `PFR_RST_BYTE;
      twowire_ctrl_r <= `PFR_RST_BYTE;
      conv_ctrl1_r <= `PFR_RST_BYTE;
      clk_ctrl_r <= `PFR_RST_BYTE;
      pwm_sel_r <= '0;
      pint_en_r <= '0;
    end else if (wr_go) begin
      if (wa == `PFR_OFS_BOOT_CFG0) boot_cfg0_r <= pfr_merge(boot_cfg0_r, wd, ws);
      if (wa == `PFR_OFS_AUX_CTRL1) aux_ctrl1_r <= pfr_merge(aux_ctrl1_r, wd, ws);
      if (wa == `PFR_OFS_TWOWIRE_CTRL) twowire_ctrl_r <= pfr_merge(twowire_ctrl_r, wd, ws);
      if (wa == `PFR_OFS_CONV_CTRL1) conv_ctrl1_r <= pfr_merge(conv_ctrl1_r, wd, ws);
      if (wa == `PFR_OFS_CLK_CTRL) clk_ctrl_r <= pfr_merge(clk_ctrl_r, wd, ws);
      if (wa == `PFR_OFS_PWM_SEL && ws[0]) pwm_sel_r <= wd[NPWM-1:0];
      if (wa == `PFR_OFS_PINT_EN) pint_en_r <= wd[NPINS-1:0];
    end
  end

  // pad output routing; applied the edge after the control write
  logic [NPINS-1:0] drv_o, drv_e;
  always_comb begin
    drv_o = gpio_out;
    drv_e = gpio_oe;
    drv_o[P_TXD] = 1'b0;
    drv_e[P_TXD] = 1'b0;
    drv_o[P_RXD] = 1'b0;
    drv_e[P_RXD] = 1'b0;
    drv_o[tx_pin ? P_RXD : P_TXD] = periph_out.uart0_txd;
    drv_e[tx_pin ? P_RXD : P_TXD] = 1'b1;
    drv_o[scl_pin_sel ? P_ASCL : P_SCL] = periph_out.twowire_scl_o;
    drv_e[scl_pin_sel ? P_ASCL : P_SCL] = periph_out.twowire_scl_oe;
    drv_o[scl_pin_sel ? P_ASDA : P_SDA] = periph_out.twowire_sda_o;
    drv_e[scl_pin_sel ? P_ASDA : P_SDA] = periph_out.twowire_sda_oe;
    drv_o[P_RST] = 1'b0;                                                 // input-only
    drv_e[P_RST] = 1'b0;
    if (ext_clk) begin
      drv_o[P_OSC] = 1'b0;
      drv_e[P_OSC] = 1'b0;
    end
    for (int i = 0; i < NPWM; i++) begin
      if (pwm_sel_r[i]) begin
        drv_o[P_PWM0 + i] = periph_out.pwm[i];
        drv_e[P_PWM0 + i] = 1'b1;
      end
    end
  end

  // registered pad and peripheral-input outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out <= '0;
      pad_oe <= '0;
      pad_rst_pullup <= 1'b1;
      gpio_in <= '0;
      pin_int_src <= '0;
      periph_in <= '1;
    end else begin
      pad_out <= drv_o;
      pad_oe <= drv_e;
      pad_rst_pullup <= rst_pin_en;
      gpio_in <= pin_s;
      pin_int_src <= pin_s & pint_en_r;
      periph_in.uart0_rxd <= uart_swap ? pin_s[P_TXD] : pin_s[P_RXD];
      periph_in.twowire_scl_i <= tw_remap ? pin_s[P_ASCL] : pin_s[P_SCL];
      periph_in.twowire_sda_i <= tw_remap ? pin_s[P_ASDA] : pin_s[P_SDA];
      periph_in.conv_ext_trigger <= trig_remap ? pin_s[P_SCL] : pin_s[P_TRIG];
      periph_in.ext_clock_in <= ext_clk ? pin_s[P_OSC] : 1'b0;
      periph_in.port3_bit0 <= ext_clk ? 1'b0 : pin_s[P_OSC];
      periph_in.port2_bit0 <= rst_pin_en ? 1'b0 : pin_s[P_RST];
      periph_in.device_reset_n <= rst_pin_en ? pin_s[P_RST] : 1'b1;
    end
  end
endmodule // pfr_remap

// ===== pfr_remap_properties.sv
/*
  concurrent checks on the ports of the pin-function remap block.
  assumes one clock aclk, synchronous active-low aresetn, three-edge pad input delay.
*/
`timescale 1ns/10ps
module pfr_props #(
  parameter int NPINS = 18
) (
  // clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // bus handshakes
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic [31:0]             s_axi_rdata,
  // pads and routed functions
  input wire logic [NPINS-1:0]        pad_in,
  input wire logic [NPINS-1:0]        pad_oe,
  input wire logic                    pad_rst_pullup,
  input wire logic [NPINS-1:0]        gpio_in,
  input wire pfr_pkg::pfr_periph_in_t periph_in,
  input wire logic [NPINS-1:0]        pin_int_src
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // pad shared with reset is input only and pulled up after reset
  property p_rst_pad_in_only;
    !pad_oe[7];
  endproperty
  a_rst_pad_in_only: assert property (p_rst_pad_in_only) else $error("reset pad driven");
  property p_pullup_after_reset;
    $rose(aresetn) |-> pad_rst_pullup;
  endproperty
  a_pullup_after_reset: assert property (p_pullup_after_reset) else $error("pull-up off after reset");
  property p_port_no_reset;
    !pad_rst_pullup |-> periph_in.device_reset_n;
  endproperty
  a_port_no_reset: assert property (p_port_no_reset) else $error("reset request while pad is port");
  // reset request follows the pad three edges later
  property p_reset_follow;
    pad_rst_pullup && $past(pad_rst_pullup, 3) && $past(aresetn) && $past(aresetn, 2) && $past(aresetn, 3)
      |-> periph_in.device_reset_n == $past(pad_in[7], 3);
  endproperty
  a_reset_follow: assert property (p_reset_follow) else $error("reset request does not follow pad");
  property p_int_src;
    (pin_int_src & ~gpio_in) == '0;
  endproperty
  a_int_src: assert property (p_int_src) else $error("interrupt source without pad level");
  // bus answers come one cycle after the request and stand until taken
  property p_wr_answer;
    $rose(s_axi_awvalid && s_axi_wvalid) && !s_axi_bvalid && !s_axi_rvalid |-> ##1 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_rd_answer;
    $rose(s_axi_arvalid) && !s_axi_bvalid && !s_axi_rvalid |-> ##1 s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read data late");
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
endmodule // pfr_props

bind pfr_remap pfr_props #(.NPINS(NPINS)) pfr_props_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .pad_in(pad_in),
  .pad_oe(pad_oe), .pad_rst_pullup(pad_rst_pullup), .gpio_in(gpio_in), .periph_in(periph_in),
  .pin_int_src(pin_int_src));

// ===== tb_top.sv
/*
  self-checking bench of the pin-function remap block over its register bus and pads.
  assumes the checker is bound to the design; the bench drives every pad itself.
*/
`timescale 1ns/10ps
module tb_top;
  logic                     aclk = 1'b0;
  logic                     aresetn = 1'b0;
  logic [11:0]              awa = '0;
  logic [11:0]              ara = '0;
  logic [31:0]              wd = '0;
  logic                     awv = 1'b0;
  logic                     wv = 1'b0;
  logic                     bre = 1'b0;
  logic                     arv = 1'b0;
  logic                     rre = 1'b0;
  logic                     bv, rv, pu;
  logic                     awr, wrr, arr;
  logic [1:0]               br, rr;
  logic [31:0]              rd;
  logic [17:0]              pin = 18'h3FFFF;
  logic [17:0]              gout = '0;
  logic [17:0]              goe = 18'h3FFFF;
  logic [17:0]              pout, poe, gin, isrc;
  pfr_pkg::pfr_periph_out_t po = '0;
  pfr_pkg::pfr_periph_in_t  pi;
  int                       err_total = 0;
  int                       total_checks = 0;

  // 100 MHz clock
  always #5 aclk = ~aclk;

  pfr_remap pfr_remap_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .pad_in(pin),
    .pad_out(pout), .pad_oe(poe), .pad_rst_pullup(pu), .gpio_out(gout), .gpio_oe(goe), .gpio_in(gin),
    .periph_out(po), .periph_in(pi), .pin_int_src(isrc));

  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bus write; each channel released at the edge where it is taken, bounded wait
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic aw_on, w_on, got;
    n = 0;
    aw_on = 1'b1;
    w_on = 1'b1;
    got = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (aw_on && awr === 1'b1) begin
        aw_on = 1'b0;
        awv <= 1'b0;
      end
      if (w_on && wrr === 1'b1) begin
        w_on = 1'b0;
        wv <= 1'b0;
      end
      if (!got && bv === 1'b1) begin
        got = 1'b1;
        bre <= 1'b0;
        chk(32'(br), 32'(er));
      end
    end while ((aw_on || w_on || !got) && n < 50);
    if (aw_on || w_on || !got) begin
      err_total++;
      summarize();
    end
  endtask

  // bus read with expected data and response, bounded wait
  task automatic rdc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int   n;
    logic ar_on, got;
    n = 0;
    ar_on = 1'b1;
    got = 1'b0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (ar_on && arr === 1'b1) begin
        ar_on = 1'b0;
        arv <= 1'b0;
      end
      if (!got && rv === 1'b1) begin
        got = 1'b1;
        rre <= 1'b0;
        chk(rd, ed);
        chk(32'(rr), 32'(er));
      end
    end while ((ar_on || !got) && n < 50);
    if (ar_on || !got) begin
      err_total++;
      summarize();
    end
  endtask

  // lets pad synchronisers and routing flops catch up
  task automatic settle;
    repeat (6) @(posedge aclk);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped place
    rdc(12'h000, 32'h000000FF, 2'h0);
    for (int i = 1; i < 7; i++) rdc(12'(i * 4), 32'h0, 2'h0);
    rdc(12'h020, 32'h0, 2'h2);
    wr(12'h020, 32'hFF, 2'h2);
    // reset pad: pull-up on and a low level requests reset, then port bit
    pin[7] <= 1'b0;
    settle();
    chk(32'(pu), 32'h1);
    chk(32'(pi.device_reset_n), 32'h0);
    wr(12'h000, 32'hFB, 2'h0);
    settle();
    chk(32'(pu), 32'h0);
    chk(32'(pi.device_reset_n), 32'h1);
    chk(32'(pi.port2_bit0), 32'h0);
    pin[7] <= 1'b1;
    settle();
    chk(32'(pi.port2_bit0), 32'h1);
    // oscillator pad as port bit, then as clock input
    for (int m = 0; m < 2; m++) begin
      wr(12'h014, 32'(m), 2'h0);
      for (int v = 0; v < 2; v++) begin
        pin[8] <= v[0];
        settle();
        chk(32'(m == 1 ? pi.ext_clock_in : pi.port3_bit0), 32'(v));
        chk(32'({pi.ext_clock_in, pi.port3_bit0, poe[8]}), m == 1 ? 32'(v << 2) : 32'((v << 1) | 1));
      end
    end
    // serial transmit and receive swap, opposite level on the other pad
    for (int m = 0; m < 2; m++) begin
      wr(12'h004, 32'(m << 2), 2'h0);
      for (int v = 0; v < 2; v++) begin
        po.uart0_txd <= v[0];
        pin[m] <= ~v[0];
        pin[1 - m] <= v[0];
        settle();
        chk(32'(pout[m]), 32'(v));
        chk(32'({poe[m], poe[1 - m]}), 32'h2);
        chk(32'(pi.uart0_rxd), 32'(v));
      end
    end
    // two-wire clock and data pads, default then alternate
    for (int m = 0; m < 2; m++) begin
      wr(12'h008, 32'(m), 2'h0);
      for (int v = 0; v < 2; v++) begin
        po.twowire_scl_o <= v[0];
        po.twowire_scl_oe <= 1'b1;
        po.twowire_sda_o <= ~v[0];
        po.twowire_sda_oe <= 1'b1;
        pin[5:2] <= m ? {~v[0], v[0], v[0], ~v[0]} : {v[0], ~v[0], ~v[0], v[0]};
        settle();
        chk(32'({pout[m * 2 + 2], pout[m * 2 + 3]}), 32'({v[0], ~v[0]}));
        chk(32'({poe[m * 2 + 2], poe[m * 2 + 3]}), 32'h3);
        chk(32'({pi.twowire_scl_i, pi.twowire_sda_i}), 32'({v[0], ~v[0]}));
      end
    end
    // conversion trigger pad, default then alternate
    for (int m = 0; m < 2; m++) begin
      wr(12'h00C, 32'(m << 6), 2'h0);
      for (int v = 0; v < 2; v++) begin
        pin[m ? 2 : 6] <= v[0];
        pin[m ? 6 : 2] <= ~v[0];
        settle();
        chk(32'(pi.conv_ext_trigger), 32'(v));
      end
    end
    // one pwm pad at a time, the rest gpio
    po.pwm <= 6'h3F;
    for (int i = 0; i < 6; i++) begin
      wr(12'h010, 32'(1 << i), 2'h0);
      settle();
      chk(32'(pout[14:9]), 32'(1 << i));
    end
    // pin interrupt enables against two pad patterns
    wr(12'h018, 32'h0002AAAA, 2'h0);
    pin <= 18'h3FFFF;
    settle();
    chk(32'(isrc), 32'h0002AAAA);
    pin <= 18'h15555;
    settle();
    chk(32'(isrc), 32'h0);
    chk(32'(gin), 32'h00015555);
    // second reset restores the configuration byte
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(12'h000, 32'h000000FF, 2'h0);
    summarize();
  end
endmodule // tb_top
